//--- hdl/astrx_pkg.sv
package astrx_pkg;
    // ----------------------------------------------------------------
    // frame and timing
    // ----------------------------------------------------------------
    localparam int          DATA_BITS      = 8;
    localparam int          OVERSAMPLE     = 16;
    localparam logic [3:0]  OVS_LAST       = 4'hF;
    localparam logic [3:0]  OVS_MID        = 4'h7;
    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam logic [15:0] DIV_RESET      = 16'h0000;
    localparam logic [7:0]  BYTE_RESET     = 8'h00;
    localparam logic [2:0]  SYNC_RESET     = 3'h7;
    // ----------------------------------------------------------------
    // address match schemes
    // ----------------------------------------------------------------
    localparam logic [1:0]  AMS_NONE       = 2'h0;
    localparam logic [1:0]  AMS_ALL_ADDR   = 2'h1;
    localparam logic [1:0]  AMS_MATCH_BOTH = 2'h2;
    localparam logic [1:0]  AMS_MATCH_DATA = 2'h3;

    typedef enum logic [2:0] {
        ASTRX_IDLE,
        ASTRX_START,
        ASTRX_DATA,
        ASTRX_NINTH,
        ASTRX_STOP1,
        ASTRX_STOP2
    } astrx_state_t;
endpackage

//--- hdl/astrx_core.sv
`timescale 1ns/1ps
// Operation
// - eight data bits, lsb first
// - optional even or odd parity bit, checked
// - low start, one or two high stops
// - new characters start only while tx enabled
// - parity ignored in nine-bit mode
// - clear-to-send input gates new characters
// - empty flag high when holding register free
// - written byte moves to shifter automatically
// - transmit interrupt while holding register empty
// - receive only while rx enabled
// - available flag high while byte held
// - receive interrupt on data and errors
// - status tells error, break or data
// - option: interrupt on errors only
// - nine-bit enable and two-bit scheme select
// - address bytes compared with node address
// - bit rate from high and low divisor bytes
// - ninth bit sits in parity slot
// - data write clears empty flag
// - sixteen-bit divider
module astrx_core
    import astrx_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       tx_enable_bit,
    input  wire logic       rx_enable_bit,
    input  wire logic       parity_enable_bit,
    input  wire logic       parity_odd_select,
    input  wire logic       two_stop_select,
    input  wire logic       clear_to_send_gate_enable,
    input  wire logic       ninth_bit_mode_enable,
    input  wire logic [1:0] address_match_scheme_select,
    input  wire logic       tx_ninth_bit_value,
    input  wire logic       rx_error_irq_only,
    input  wire logic [7:0] node_address,
    input  wire logic [7:0] divisor_high,
    input  wire logic [7:0] divisor_low,
    input  wire logic       tx_data_write,
    input  wire logic [7:0] tx_data,
    input  wire logic       rx_data_read,
    input  wire logic       clear_to_send_n,
    input  wire logic       rx_pin,
    output logic            tx_pin,
    output logic            tx_holding_empty_flag,
    output logic            tx_irq,
    output logic            rx_byte_available_flag,
    output logic [7:0]      rx_data,
    output logic            rx_ninth_bit,
    output logic            rx_new_frame,
    output logic            rx_parity_error,
    output logic            rx_framing_error,
    output logic            rx_break,
    output logic            rx_overrun,
    output logic            rx_irq
);
    // ----------------------------------------------------------------
    // pin synchronisers and baud tick
    // ----------------------------------------------------------------
    logic [2:0]  rxs_r, rxs_nxt, ctss_r, ctss_nxt;
    logic        rx_in_r, rx_in_nxt, cts_n_r, cts_n_nxt;
    logic [15:0] div_r, div_nxt;
    logic        tick_r, tick_nxt;

    always_comb begin
        rxs_nxt   = {rxs_r[1:0], rx_pin};
        ctss_nxt  = {ctss_r[1:0], clear_to_send_n};
        // a change counts only once the last two stages agree
        rx_in_nxt = (rxs_r[2] == rxs_r[1]) ? rxs_r[2] : rx_in_r;
        cts_n_nxt = (ctss_r[2] == ctss_r[1]) ? ctss_r[2] : cts_n_r;
        // one tick per sixteenth of a bit; divisor 0 behaves as 1
        tick_nxt  = (div_r == 16'h0000);
        div_nxt   = tick_nxt ? ({divisor_high, divisor_low} - 16'h0001)
                             : div_r - 16'h0001;
        if ({divisor_high, divisor_low} == 16'h0000) begin
            div_nxt = DIV_RESET;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rxs_r   <= SYNC_RESET;
            ctss_r  <= SYNC_RESET;
            rx_in_r <= 1'b1;
            cts_n_r <= 1'b1;
            div_r   <= DIV_RESET;
            tick_r  <= 1'b0;
        end else begin
            rxs_r   <= rxs_nxt;
            ctss_r  <= ctss_nxt;
            rx_in_r <= rx_in_nxt;
            cts_n_r <= cts_n_nxt;
            div_r   <= div_nxt;
            tick_r  <= tick_nxt;
        end
    end

    // ----------------------------------------------------------------
    // transmitter
    // ----------------------------------------------------------------
    astrx_state_t tst_r, tst_nxt;
    logic [7:0]   thold_r, thold_nxt, tsh_r, tsh_nxt;
    logic         tnin_r, tnin_nxt, tempty_r, tempty_nxt, tpin_r, tpin_nxt;
    logic [3:0]   tovs_r, tovs_nxt;
    logic [2:0]   tbit_r, tbit_nxt;
    logic         t_par_on, t_bitend;

    always_comb begin
        tst_nxt    = tst_r;
        thold_nxt  = thold_r;
        tsh_nxt    = tsh_r;
        tnin_nxt   = tnin_r;
        tempty_nxt = tempty_r;
        tpin_nxt   = tpin_r;
        tovs_nxt   = tovs_r;
        tbit_nxt   = tbit_r;
        t_par_on   = parity_enable_bit && !ninth_bit_mode_enable;
        t_bitend   = tick_r && (tovs_r == OVS_LAST);
        if (tick_r) begin
            tovs_nxt = tovs_r + 4'h1;
        end
        unique case (tst_r)
            ASTRX_IDLE: begin
                tpin_nxt = 1'b1;
                // cts is sampled before each new character only
                if (!tempty_r && tx_enable_bit
                        && !(clear_to_send_gate_enable && cts_n_r)) begin
                    tsh_nxt    = thold_r;
                    tnin_nxt   = ninth_bit_mode_enable ? tx_ninth_bit_value
                                                       : ^thold_r ^ parity_odd_select;
                    tempty_nxt = 1'b1;
                    tpin_nxt   = 1'b0;
                    tovs_nxt   = 4'h0;
                    tst_nxt    = ASTRX_START;
                end
            end
            ASTRX_START: if (t_bitend) begin
                tpin_nxt = tsh_r[0];
                tbit_nxt = 3'h0;
                tst_nxt  = ASTRX_DATA;
            end
            ASTRX_DATA: if (t_bitend) begin
                tsh_nxt  = {1'b0, tsh_r[7:1]};
                tbit_nxt = tbit_r + 3'h1;
                tpin_nxt = tsh_r[1];
                if (tbit_r == BIT_LAST) begin
                    tpin_nxt = (ninth_bit_mode_enable || t_par_on) ? tnin_r : 1'b1;
                    tst_nxt  = (ninth_bit_mode_enable || t_par_on) ? ASTRX_NINTH
                                                                   : ASTRX_STOP1;
                end
            end
            ASTRX_NINTH: if (t_bitend) begin
                tpin_nxt = 1'b1;
                tst_nxt  = ASTRX_STOP1;
            end
            ASTRX_STOP1: if (t_bitend) begin
                tst_nxt = two_stop_select ? ASTRX_STOP2 : ASTRX_IDLE;
            end
            default: if (t_bitend) begin
                tst_nxt = ASTRX_IDLE;
            end
        endcase
        if (tx_data_write) begin
            thold_nxt  = tx_data;
            tempty_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            tst_r                      <= ASTRX_IDLE;
            {thold_r, tsh_r}           <= {BYTE_RESET, BYTE_RESET};
            {tnin_r, tempty_r, tpin_r} <= 3'h3;
            {tovs_r, tbit_r}           <= 7'h00;
        end else begin
            tst_r                      <= tst_nxt;
            {thold_r, tsh_r}           <= {thold_nxt, tsh_nxt};
            {tnin_r, tempty_r, tpin_r} <= {tnin_nxt, tempty_nxt, tpin_nxt};
            {tovs_r, tbit_r}           <= {tovs_nxt, tbit_nxt};
        end
    end

    assign tx_pin                = tpin_r;
    assign tx_holding_empty_flag = tempty_r;
    assign tx_irq                = tempty_r;

    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    astrx_state_t rst_r, rst_nxt;
    logic [7:0]   rsh_r, rsh_nxt, rdat_r, rdat_nxt;
    logic [3:0]   rovs_r, rovs_nxt;
    logic [2:0]   rbit_r, rbit_nxt;
    logic         rnin_r, rnin_nxt, rpar_r, rpar_nxt, rzero_r, rzero_nxt;
    logic         ravl_r, ravl_nxt, rnine_r, rnine_nxt, rnew_r, rnew_nxt;
    logic         rpe_r, rpe_nxt, rfe_r, rfe_nxt, rbrk_r, rbrk_nxt, rov_r, rov_nxt;
    logic         rirq_r, rirq_nxt, ract_r, ract_nxt, rfirst_r, rfirst_nxt;
    logic         r_mid, r_par_on, r_deliver, r_err, r_irq_data;

    always_comb begin
        rst_nxt              = rst_r;
        {rsh_nxt, rdat_nxt}  = {rsh_r, rdat_r};
        {rovs_nxt, rbit_nxt} = {rovs_r, rbit_r};
        {rnin_nxt, rpar_nxt, rzero_nxt, ravl_nxt, rnine_nxt, rnew_nxt}
            = {rnin_r, rpar_r, rzero_r, ravl_r, rnine_r, rnew_r};
        {rpe_nxt, rfe_nxt, rbrk_nxt, rov_nxt, ract_nxt, rfirst_nxt}
            = {rpe_r, rfe_r, rbrk_r, rov_r, ract_r, rfirst_r};
        r_deliver  = 1'b0;
        r_err      = 1'b0;
        r_irq_data = 1'b0;
        r_par_on   = parity_enable_bit && !ninth_bit_mode_enable;
        r_mid      = tick_r && (rovs_r == OVS_MID);
        if (tick_r) begin
            rovs_nxt = rovs_r + 4'h1;
        end
        // reading the data register clears the flags; set below wins
        if (rx_data_read) begin
            ravl_nxt = 1'b0;
            rpe_nxt  = 1'b0;
            rfe_nxt  = 1'b0;
            rbrk_nxt = 1'b0;
            rov_nxt  = 1'b0;
        end
        unique case (rst_r)
            ASTRX_IDLE: begin
                if (rx_enable_bit && !rx_in_r) begin
                    rovs_nxt = 4'h0;
                    rst_nxt  = ASTRX_START;
                end
            end
            ASTRX_START: if (r_mid) begin
                // a glitch shorter than half a bit is not a start
                rst_nxt   = rx_in_r ? ASTRX_IDLE : ASTRX_DATA;
                rbit_nxt  = 3'h0;
                rzero_nxt = 1'b1;
            end
            ASTRX_DATA: if (r_mid) begin
                rsh_nxt   = {rx_in_r, rsh_r[7:1]};
                rzero_nxt = rzero_r && !rx_in_r;
                rbit_nxt  = rbit_r + 3'h1;
                if (rbit_r == BIT_LAST) begin
                    rst_nxt = (ninth_bit_mode_enable || r_par_on) ? ASTRX_NINTH
                                                                  : ASTRX_STOP1;
                end
            end
            ASTRX_NINTH: if (r_mid) begin
                rnin_nxt  = rx_in_r;
                rpar_nxt  = r_par_on && (^rsh_r ^ parity_odd_select ^ rx_in_r);
                rzero_nxt = rzero_r && !rx_in_r;
                rst_nxt   = ASTRX_STOP1;
            end
            default: if (r_mid) begin
                // only the first stop bit is checked; a second is tolerated
                rst_nxt = ASTRX_IDLE;
                if (rx_enable_bit) begin
                    r_deliver = 1'b1;
                end
            end
        endcase
        if (r_deliver) begin
            if (ninth_bit_mode_enable && address_match_scheme_select != AMS_NONE) begin
                if (rnin_r) begin
                    // address byte: in the match schemes, match decides which frames are kept
                    if (address_match_scheme_select == AMS_ALL_ADDR) begin
                        r_irq_data = 1'b1;
                    end else begin
                        ract_nxt   = (rsh_r == node_address);
                        rfirst_nxt = (rsh_r == node_address);
                        r_irq_data = (rsh_r == node_address)
                                     && address_match_scheme_select == AMS_MATCH_BOTH;
                    end
                end else begin
                    r_irq_data = (address_match_scheme_select != AMS_ALL_ADDR) && ract_r
                                 && rx_in_r;
                    rfirst_nxt = r_irq_data ? 1'b0 : rfirst_r;
                end
            end else begin
                r_irq_data = 1'b1;
            end
            r_err = r_par_on && rpar_r || !rx_in_r;
            if (r_irq_data || r_err) begin
                if (ravl_r && !rx_data_read) begin
                    // keep the unread byte; the new frame is dropped and overrun set
                    rov_nxt = 1'b1;
                end else begin
                    rdat_nxt  = rsh_r;
                    rnine_nxt = rnin_r;
                    rnew_nxt  = !rnin_r && rfirst_r;
                    ravl_nxt  = 1'b1;
                    rpe_nxt   = r_par_on && rpar_r;
                    rfe_nxt   = !rx_in_r;
                    rbrk_nxt  = !rx_in_r && rzero_r;
                end
            end
        end
        // data interrupts may be masked; errors always interrupt
        rirq_nxt = (ravl_nxt && !rx_error_irq_only)
                   || rpe_nxt || rfe_nxt || rbrk_nxt || rov_nxt;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rst_r            <= ASTRX_IDLE;
            {rsh_r, rdat_r}  <= {BYTE_RESET, BYTE_RESET};
            {rovs_r, rbit_r} <= 7'h00;
            {rnin_r, rpar_r, rzero_r, ravl_r, rnine_r, rnew_r, rpe_r} <= 7'h00;
            {rfe_r, rbrk_r, rov_r, rirq_r, ract_r, rfirst_r}          <= 6'h00;
        end else begin
            rst_r            <= rst_nxt;
            {rsh_r, rdat_r}  <= {rsh_nxt, rdat_nxt};
            {rovs_r, rbit_r} <= {rovs_nxt, rbit_nxt};
            {rnin_r, rpar_r, rzero_r, ravl_r, rnine_r, rnew_r, rpe_r}
                <= {rnin_nxt, rpar_nxt, rzero_nxt, ravl_nxt, rnine_nxt, rnew_nxt, rpe_nxt};
            {rfe_r, rbrk_r, rov_r, rirq_r, ract_r, rfirst_r}
                <= {rfe_nxt, rbrk_nxt, rov_nxt, rirq_nxt, ract_nxt, rfirst_nxt};
        end
    end

    assign rx_byte_available_flag = ravl_r;
    assign rx_data                = rdat_r;
    assign rx_ninth_bit           = rnine_r;
    assign rx_new_frame           = rnew_r;
    assign rx_parity_error        = rpe_r;
    assign rx_framing_error       = rfe_r;
    assign rx_break               = rbrk_r;
    assign rx_overrun             = rov_r;
    assign rx_irq                 = rirq_r;
endmodule

//--- verif/astrx_chk.sv
`timescale 1ns/1ps
module astrx_chk (
    input wire logic mclk,
    input wire logic reset,
    input wire logic tx_enable_bit,
    input wire logic rx_enable_bit,
    input wire logic clear_to_send_gate_enable,
    input wire logic rx_error_irq_only,
    input wire logic tx_data_write,
    input wire logic rx_data_read,
    input wire logic clear_to_send_n,
    input wire logic tx_pin,
    input wire logic tx_holding_empty_flag,
    input wire logic tx_irq,
    input wire logic rx_byte_available_flag,
    input wire logic rx_irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // ----
    // transmit
    // ----
    sequence tx_pending;
        !tx_holding_empty_flag && !tx_data_write;
    endsequence
    // five cycles so the pin has passed the synchroniser
    sequence cts_held;
        clear_to_send_n [*5];
    endsequence
    a_reset_idle: assert property (disable iff (1'b0)
        reset |=> tx_pin && tx_holding_empty_flag && !rx_byte_available_flag)
        else $error("outputs not idle after reset");
    a_irq_follows_empty: assert property (tx_irq == tx_holding_empty_flag)
        else $error("tx irq differs from empty flag");
    a_write_clears_empty: assert property (tx_data_write |=> !tx_holding_empty_flag)
        else $error("empty flag set after write");
    a_tx_off_holds: assert property (!tx_enable_bit ##0 tx_pending
        |=> !tx_holding_empty_flag) else $error("byte loaded while disabled");
    a_cts_gate_holds: assert property (cts_held ##0 clear_to_send_gate_enable
        ##0 tx_pending |=> !tx_holding_empty_flag) else $error("byte loaded while held off");
    a_auto_load: assert property (tx_pending ##0 tx_enable_bit
        ##0 !clear_to_send_gate_enable |-> ##[1:800] (tx_holding_empty_flag
        || !tx_enable_bit || clear_to_send_gate_enable)) else $error("pending byte never sent");
    a_low_bit_len: assert property ($fell(tx_pin) |-> !tx_pin [*8])
        else $error("low bit too short");
    a_high_bit_len: assert property ($rose(tx_pin) |-> tx_pin [*8])
        else $error("high bit too short");
    // ----
    // receive
    // ----
    a_read_clears: assert property (rx_data_read && rx_byte_available_flag
        |=> !rx_byte_available_flag) else $error("read left byte available");
    a_rx_off_quiet: assert property (!rx_enable_bit && !rx_byte_available_flag
        |=> !rx_byte_available_flag) else $error("byte taken while disabled");
    a_data_irq: assert property ($rose(rx_byte_available_flag) && !rx_error_irq_only
        |-> ##[0:1] rx_irq) else $error("no irq for new byte");
endmodule

bind astrx_core astrx_chk chk_u (
    .mclk(mclk), .reset(reset), .tx_enable_bit(tx_enable_bit), .rx_enable_bit(rx_enable_bit),
    .clear_to_send_gate_enable(clear_to_send_gate_enable),
    .rx_error_irq_only(rx_error_irq_only), .tx_data_write(tx_data_write),
    .rx_data_read(rx_data_read), .clear_to_send_n(clear_to_send_n), .tx_pin(tx_pin),
    .tx_holding_empty_flag(tx_holding_empty_flag), .tx_irq(tx_irq),
    .rx_byte_available_flag(rx_byte_available_flag), .rx_irq(rx_irq)
);

//--- verif/astrx_node.sv
`timescale 1ns/1ps
module astrx_node (
    input  wire logic mclk,
    input  wire logic tx_pin,
    output logic      rx_pin,
    output logic      clear_to_send_n
);
    int          bit_len   = 16;
    int          frame_len = 10;
    logic [11:0] got_q[$];
    logic [11:0] w;
    initial begin
        rx_pin = 1'b1;
        clear_to_send_n = 1'b0;
    end
    // ----
    // capture frames at bit centres
    // ----
    initial begin
        forever begin
            @(negedge tx_pin);
            repeat (bit_len / 2) @(posedge mclk);
            w = '1;
            for (int i = 0; i < frame_len; i++) begin
                if (i > 0) repeat (bit_len) @(posedge mclk);
                w[i] = tx_pin;
            end
            got_q.push_back(w);
        end
    end
    // ----
    // send frames
    // ----
    // a low last bit is cut short so the line is high again before a false start confirms
    task automatic send(input logic [11:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            #1 rx_pin = bits[i];
            repeat ((i == n - 1 && !bits[i]) ? bit_len * 3 / 4 : bit_len - 1) @(posedge mclk);
        end
        @(posedge mclk);
        #1 rx_pin = 1'b1;
    endtask
endmodule

//--- verif/astrx_core_tb.sv
`timescale 1ns/1ps
module astrx_core_tb;
    localparam logic [15:0] DLV = 16'h8C5F;
    logic        mclk, reset, tx_enable_bit, rx_enable_bit, parity_enable_bit;
    logic        parity_odd_select, two_stop_select, clear_to_send_gate_enable;
    logic        ninth_bit_mode_enable, tx_ninth_bit_value, rx_error_irq_only;
    logic        tx_data_write, rx_data_read, clear_to_send_n, rx_pin, tx_pin, tx_irq;
    logic        tx_holding_empty_flag, rx_byte_available_flag, rx_ninth_bit, rx_new_frame;
    logic        rx_parity_error, rx_framing_error, rx_break, rx_overrun, rx_irq;
    logic [1:0]  address_match_scheme_select;
    logic [7:0]  node_address, divisor_high, divisor_low, tx_data, rx_data;
    logic [11:0] exp_q[$];
    logic [31:0] seed;
    int          n_errors = 0, total_checks = 0, cyc = 0;
    astrx_core dut_u (.mclk, .reset, .tx_enable_bit, .rx_enable_bit, .parity_enable_bit,
        .parity_odd_select, .two_stop_select, .clear_to_send_gate_enable,
        .ninth_bit_mode_enable, .address_match_scheme_select, .tx_ninth_bit_value,
        .rx_error_irq_only, .node_address, .divisor_high, .divisor_low, .tx_data_write,
        .tx_data, .rx_data_read, .clear_to_send_n, .rx_pin, .tx_pin, .tx_holding_empty_flag,
        .tx_irq, .rx_byte_available_flag, .rx_data, .rx_ninth_bit, .rx_new_frame,
        .rx_parity_error, .rx_framing_error, .rx_break, .rx_overrun, .rx_irq);
    astrx_node node_u (.mclk, .tx_pin, .rx_pin, .clear_to_send_n);
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors++;
            summarize();
        end
    end
    // ----
    // helpers
    // ----
    task automatic summarize();
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [11:0] mk_frame(input logic [7:0] d, input logic u9,
                                             input logic b9, input logic bad);
        logic [11:0] f;
        f = {3'h7, d, 1'h0};
        if (u9) f[9] = b9;
        if (bad) f[4'h9 + u9] = 1'h0;
        return f;
    endfunction
    task automatic set_len();
        node_u.bit_len = 16 * ((divisor_low == 8'h00) ? 1 : int'(divisor_low));
        node_u.frame_len = 10 + (ninth_bit_mode_enable | parity_enable_bit) + two_stop_select;
    endtask
    task automatic tx_one(input logic [7:0] d);
        for (int i = 0; i < 2000 && tx_holding_empty_flag !== 1'b1; i++) tick();
        tx_data = d;
        tx_data_write = 1'b1;
        tick();
        chk_flag(tx_holding_empty_flag, 1'b0);
        tx_data_write = 1'b0;
        tick();
        exp_q.push_back(mk_frame(d, ninth_bit_mode_enable | parity_enable_bit,
            ninth_bit_mode_enable ? tx_ninth_bit_value : ^d ^ parity_odd_select, 1'b0));
    endtask
    task automatic tx_drain();
        for (int i = 0; i < 3000 && node_u.got_q.size() < exp_q.size(); i++) tick();
        repeat (64) tick();
        chk_word(12'(node_u.got_q.size()), 12'(exp_q.size()));
        while (exp_q.size() > 0 && node_u.got_q.size() > 0)
            chk_word(node_u.got_q.pop_front(), exp_q.pop_front());
        exp_q.delete();
    endtask
    task automatic rx_frame(input logic [7:0] d, input logic b9, input logic bad,
                            input logic dlv);
        logic u9, pe;
        u9 = ninth_bit_mode_enable | parity_enable_bit;
        pe = !ninth_bit_mode_enable && parity_enable_bit && (b9 !== (^d ^ parity_odd_select));
        node_u.send(mk_frame(d, u9, b9, bad), 10 + u9 + two_stop_select);
        repeat (8) tick();
        chk_flag(rx_byte_available_flag, dlv | pe | bad);
        chk_flag(rx_parity_error, pe);
        chk_flag(rx_framing_error, bad);
        chk_flag(rx_break, bad & (d == 8'h00) & ~(u9 & b9));
        chk_flag(rx_irq, (dlv & ~rx_error_irq_only) | pe | bad);
        if (dlv) chk_word({4'h0, d}, {4'h0, rx_data});
        if (dlv && ninth_bit_mode_enable) chk_flag(rx_ninth_bit, b9);
    endtask
    task automatic rd();
        rx_data_read = 1'b1;
        tick();
        rx_data_read = 1'b0;
        tick();
        chk_flag(rx_byte_available_flag | rx_parity_error | rx_framing_error, 1'b0);
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        reset = 1'b1;
        {tx_enable_bit, rx_enable_bit, parity_enable_bit, parity_odd_select, two_stop_select,
         clear_to_send_gate_enable, ninth_bit_mode_enable, tx_ninth_bit_value,
         rx_error_irq_only, tx_data_write, rx_data_read} = 11'h000;
        address_match_scheme_select = 2'h0;
        node_address = 8'h5C;
        {divisor_high, divisor_low, tx_data} = 24'h000100;
        seed = 32'h75B2;
        repeat (8) @(posedge mclk);
        #1 reset = 1'b0;
        chk_flag(tx_pin & tx_holding_empty_flag & tx_irq, 1'b1);
        chk_flag(rx_byte_available_flag, 1'b0);
        {tx_enable_bit, rx_enable_bit} = 2'h3;
        for (int k = 0; k < 12; k++) begin
            seed = lfsr(seed);
            {parity_enable_bit, parity_odd_select, two_stop_select, ninth_bit_mode_enable,
             tx_ninth_bit_value} = seed[4:0];
            divisor_low = (k == 0) ? 8'h00 : 8'h01 + 8'(k % 2);
            set_len();
            tx_one(seed[15:8]);
            tx_one((k == 1) ? 8'hFF : seed[23:16]);
            tx_drain();
        end
        tx_enable_bit = 1'b0;
        tx_one(8'hA5);
        repeat (300) tick();
        chk_flag(tx_holding_empty_flag, 1'b0);
        tx_enable_bit = 1'b1;
        tx_drain();
        clear_to_send_gate_enable = 1'b1;
        node_u.clear_to_send_n = 1'b1;
        // hold-off must clear the pin synchroniser before the write
        repeat (4) tick();
        tx_one(8'h3C);
        repeat (300) tick();
        chk_flag(tx_holding_empty_flag, 1'b0);
        node_u.clear_to_send_n = 1'b0;
        tx_drain();
        {clear_to_send_gate_enable, node_u.clear_to_send_n} = 2'h1;
        tx_one(8'hC3);
        tx_drain();
        {ninth_bit_mode_enable, parity_enable_bit, divisor_low} = 10'h101;
        set_len();
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            {two_stop_select, parity_odd_select} = {seed[1] & (k != 4), seed[0]};
            rx_frame(seed[15:8], ^seed[15:8] ^ seed[0] ^ (k == 2), k == 4, 1'b1);
            rd();
        end
        {two_stop_select, parity_enable_bit} = 2'h0;
        rx_frame(8'h00, 1'b1, 1'b1, 1'b1);
        rd();
        rx_error_irq_only = 1'b1;
        rx_frame(8'h5A, 1'b1, 1'b0, 1'b1);
        rd();
        rx_frame(8'h5A, 1'b1, 1'b1, 1'b1);
        rd();
        {rx_error_irq_only, rx_enable_bit} = 2'h0;
        rx_frame(8'h81, 1'b1, 1'b0, 1'b0);
        rd();
        // parity left on: nine-bit mode must ignore it
        {rx_enable_bit, ninth_bit_mode_enable, parity_enable_bit} = 3'h7;
        for (int s = 0; s < 4; s++) begin
            address_match_scheme_select = 2'(s);
            for (int j = 0; j < 4; j++) begin
                seed = lfsr(seed);
                rx_frame((j == 0) ? 8'h33 : (j == 2) ? 8'h5C : seed[7:0], ~j[0], 1'b0,
                         DLV[s * 4 + j]);
                if (s > 1 && j == 3) chk_flag(rx_new_frame, 1'b1);
                rd();
            end
        end
        // two frames with no read between: the first byte must be kept
        address_match_scheme_select = 2'h0;
        node_u.send(mk_frame(8'h11, 1'b1, 1'b0, 1'b0), 11);
        node_u.send(mk_frame(8'h22, 1'b1, 1'b0, 1'b0), 11);
        repeat (8) tick();
        chk_flag(rx_overrun, 1'b1);
        chk_word({4'h0, rx_data}, 12'h011);
        chk_flag(rx_irq, 1'b1);
        rd();
        summarize();
    end
endmodule
